// ### spps_evq.sv
/*
 * Circular event queue; a push into a full queue overwrites the oldest entry.
 * Assumes push and pop come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module spps_evq #(
	parameter int W     = spps_pkg::EVENT_W,
	parameter int DEPTH = spps_pkg::MAX_EVENTS,
	parameter int CW    = $clog2(DEPTH + 1),
	parameter int AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          ce,
	// write side
	input  wire logic          push,
	input  wire logic [W-1:0]  push_data,
	// read side
	input  wire logic          pop,
	output logic      [W-1:0]  head,
	output logic      [CW-1:0] count
);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic          do_pop, ovw;

	function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// ==========================================================
	// pointers
	always_comb
	begin
		do_pop = pop && (cnt_q != '0);
		ovw    = push && (cnt_q == CW'(DEPTH)) && !do_pop;
		wr_d   = push ? wrap_inc(wr_q) : wr_q;
		rd_d   = (do_pop || ovw) ? wrap_inc(rd_q) : rd_q; // RULE_07
		cnt_d  = cnt_q;
		if (push && !ovw && !do_pop)
			cnt_d = cnt_q + CW'(1);
		else if (do_pop && !push)
			cnt_d = cnt_q - CW'(1);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else if (ce)
		begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (ce && push)
			mem[wr_q] <= push_data;
	end

	assign head  = mem[rd_q];
	assign count = cnt_q;

	// ==========================================================
	// checks
	property p_evq_bounded;
		@(posedge clk) disable iff (!rst_b)
		cnt_q <= CW'(DEPTH);
	endproperty
	a_evq_bounded: assert property (p_evq_bounded) else $error("event queue overfilled"); // RULE_07

	property p_evq_overwrite;
		@(posedge clk) disable iff (!rst_b)
		ce && push && !pop && (cnt_q == CW'(DEPTH)) |=> (cnt_q == CW'(DEPTH)) && (rd_q == $past(wr_d));
	endproperty
	a_evq_overwrite: assert property (p_evq_overwrite) else $error("full push did not drop oldest"); // RULE_07

endmodule
`default_nettype wire

// ### spps_host_model.sv
/*
 * Host-side model of the packet client: sends request packets on the byte
 * link and collects every reply byte that it accepts.
 * Assumes the server and this model share one clock; slow stalls tx_ready.
 */
`timescale 1ns/1ps
`default_nettype none
module spps_host_model (
	// clock
	input  wire logic       clk,
	// request bytes toward the server
	output logic            rx_valid,
	output logic      [7:0] rx_byte,
	// reply bytes from the server
	input  wire logic       tx_valid_q,
	input  wire logic [7:0] tx_byte_q,
	output logic            tx_ready,
	// stall control
	input  wire logic       slow
);
	logic [7:0] got[$];

	initial
	begin
		rx_valid = 1'b0;
		rx_byte  = 8'h00;
		tx_ready = 1'b1;
	end

	// ==========================================================
	// reply side
	always @(negedge clk)
		tx_ready <= slow ? ~tx_ready : 1'b1;

	// only bytes really handed over are read
	always @(posedge clk)
		if (tx_valid_q === 1'b1 && tx_ready === 1'b1)
			got.push_back(tx_byte_q);

	// ==========================================================
	// request side
	task automatic send(input logic [7:0] rtn, input logic [7:0] pl[$], input logic [7:0] bad, input int lead);
		logic [7:0] s;
		logic [7:0] f[$];
		s = rtn + 8'(pl.size());
		foreach (pl[i])
			s += pl[i];
		repeat (lead) f.push_back(8'h55);
		f.push_back(8'hAC);
		f.push_back(rtn);
		f.push_back(8'(pl.size()));
		f = {f, pl};
		f.push_back((~s + 8'h01) ^ bad);
		foreach (f[i])
		begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_byte  = f[i];
		end
		@(negedge clk);
		rx_valid = 1'b0;
		// idle line must not keep the last byte
		rx_byte  = ~rx_byte;
	endtask
endmodule
`default_nettype wire

// ### spps_pkg.sv
/*
 * Shared constants and types of the serial call protocol packet server.
 * Assumes a 100 MHz system clock; used by spps_server and spps_evq.
 */
package spps_pkg;

	// ==========================================================
	// packet framing
	localparam logic [7:0] PACKET_BEGIN_MARKER       = 8'hAC;
	localparam logic [7:0] ROUTINE_FIRST_CODE        = 8'h01;
	localparam logic [7:0] ROUTINE_LAST_CODE         = 8'h28;
	localparam logic [7:0] SYSTEM_VERSION_QUERY_CODE = 8'h02;
	localparam logic [7:0] PORT_DETAIL_QUERY_CODE    = 8'h08;
	localparam logic [7:0] FETCH_EVENTS_CODE         = 8'h28;

	// ==========================================================
	// payload lengths
	localparam logic [7:0] PARAM_PAYLOAD_LEN   = 8'h05;
	localparam logic [7:0] VERSION_PAYLOAD_LEN = 8'h10;
	localparam logic [7:0] DETAIL_PAYLOAD_LEN  = 8'h11;
	localparam logic [7:0] EVENT_BYTES         = 8'h03;
	localparam int         MAX_EVENTS          = 85;
	localparam int         EVENT_W             = 24;
	localparam int         REPLY_W             = 136;
	localparam logic [8:0] FRAME_OVERHEAD      = 9'h003;

	// ==========================================================
	// timing
	localparam longint unsigned CLK_HZ          = 100_000_000;
	localparam longint unsigned BACKUP_PERIOD_S = 30;
	localparam longint unsigned BACKUP_CYCLES   = BACKUP_PERIOD_S * CLK_HZ;
	localparam int              TIMER_W         = 32;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_HUNT   = 3'b000,
		ST_ROUT   = 3'b001,
		ST_LEN    = 3'b010,
		ST_DATA   = 3'b011,
		ST_CSUM   = 3'b100,
		ST_CALL   = 3'b101,
		ST_SEND   = 3'b110,
		ST_BACKUP = 3'b111
	} spps_state_t;

	typedef struct packed {
		logic [7:0]  type_code;
		logic [7:0]  parm_a;
		logic [7:0]  parm_b;
	} spps_event_t;

	typedef struct packed {
		logic [7:0]  result;
		logic [7:0]  detection;
		logic [7:0]  classification;
		logic [15:0] current;
		logic [15:0] supply_voltage_field;
		logic [15:0] chip_revision_text;
		logic [63:0] code_revision_text;
	} spps_detail_t;

	typedef struct packed {
		logic [7:0]   short_param_byte;
		logic [31:0]  long_param_word;
		spps_detail_t detail;
	} spps_resp_t;

	typedef struct packed {
		logic [7:0]  routine;
		logic [7:0]  short_param_byte;
		logic [31:0] long_param_word;
	} spps_call_t;

endpackage

// ### spps_server.sv
/*
 * Device-side packet server: parses request packets from the host byte link,
 * calls the manager, answers in parameter, version, port detail or event layout,
 * and runs the periodic configuration backup that silences the link.
 * Assumes rx/tx byte handshakes come from link logic on the same clock.
 */
// What this block and its host do
// (RULE_01) long parameter word goes big-end first
// (RULE_02) selector in short byte, results per routine
// (RULE_03) version reply: 16 bytes, two text fields
// (RULE_04) port detail reply: 17 bytes, fixed fields
// (RULE_05) host ignores detail fields after nonzero result
// (RULE_06) current and voltage sent big-end first
// (RULE_07) events kept circularly, oldest overwritten
// (RULE_08) fetch returns all queued events at once
// (RULE_09) three bytes per event, up to 85
// (RULE_10) host polls for events periodically
// (RULE_11) host retries or gives up after one second
// (RULE_12) host receives blocking only when data waits
// (RULE_13) bad checksum or routine dropped silently
// (RULE_14) every 30 s save changed configuration
// (RULE_15) link deaf and mute during save
// (RULE_16) packets start with marker, resync on it
// (RULE_17) checksum makes routine-to-end sum zero
// (RULE_18) parameter payload always five bytes
// (RULE_19) forty routines; reply echoes routine code
// (RULE_20) unused parameter bytes sent as zero
`timescale 1ns/1ps
`default_nettype none
module spps_server #(
	parameter longint unsigned BACKUP_CYCLES = spps_pkg::BACKUP_CYCLES,
	parameter int              EVQ_DEPTH     = spps_pkg::MAX_EVENTS
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 ce,
	// received bytes
	input  wire logic                 rx_valid,
	input  wire logic [7:0]           rx_byte,
	// sent bytes
	output logic                      tx_valid_q,
	output logic      [7:0]           tx_byte_q,
	input  wire logic                 tx_ready,
	// manager calls
	output logic                      call_valid_q,
	output spps_pkg::spps_call_t      call_q,
	input  wire logic                 resp_valid,
	input  wire spps_pkg::spps_resp_t resp,
	// static version texts
	input  wire logic [63:0]          manager_version_text,
	input  wire logic [63:0]          platform_version_text,
	// event source
	input  wire logic                 ev_valid,
	input  wire spps_pkg::spps_event_t ev,
	// configuration backup
	input  wire logic                 cfg_changed,
	input  wire logic                 nvm_done,
	output logic                      nvm_start_q,
	output logic                      link_deaf_q
);

	localparam int CW = $clog2(EVQ_DEPTH + 1);

	spps_pkg::spps_state_t st_q, st_d;
	logic [7:0]   rout_q, rout_d, rlen_q, rlen_d, rsum_q, rsum_d;
	logic [7:0]   rcnt_q, rcnt_d, len_q, len_d, tsum_q, tsum_d;
	logic [39:0]  par_q, par_d;
	logic [spps_pkg::REPLY_W-1:0] rep_q, rep_d;
	logic [8:0]   idx_q, idx_d, last_idx;
	logic [1:0]   sub_q, sub_d;
	logic         evs_q, evs_d, txv_d, callv_d, nvms_d, deaf_d;
	logic [7:0]   txb_d, nb, dix;
	spps_pkg::spps_call_t call_d;
	logic         rx, rout_ok, pop;
	spps_pkg::spps_event_t head;
	logic [CW-1:0] evcnt;
	logic [spps_pkg::TIMER_W-1:0] tmr_q, tmr_d;
	logic         pend_q, pend_d, tick;

	spps_evq #(
		.W     (spps_pkg::EVENT_W),
		.DEPTH (EVQ_DEPTH)
	) u_evq (
		.clk       (clk),
		.rst_b     (rst_b),
		.ce        (ce),
		.push      (ev_valid),
		.push_data (ev),
		.pop       (pop),
		.head      (head),
		.count     (evcnt)
	);

	// ==========================================================
	// backup timer
	always_comb
	begin
		tick   = (tmr_q == spps_pkg::TIMER_W'(BACKUP_CYCLES - 1));
		tmr_d  = tick ? '0 : tmr_q + spps_pkg::TIMER_W'(1);
		pend_d = pend_q;
		if (tick && cfg_changed)
			pend_d = 1'b1; // RULE_14
		else if (st_q == spps_pkg::ST_BACKUP)
			pend_d = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			tmr_q  <= '0;
			pend_q <= 1'b0;
		end
		else if (ce)
		begin
			tmr_q  <= tmr_d;
			pend_q <= pend_d;
		end
	end

	// ==========================================================
	// packet engine
	always_comb
	begin
		rx       = rx_valid && (st_q != spps_pkg::ST_BACKUP); // RULE_15
		rout_ok  = (rout_q >= spps_pkg::ROUTINE_FIRST_CODE) && (rout_q <= spps_pkg::ROUTINE_LAST_CODE);
		last_idx = {1'b0, len_q} + spps_pkg::FRAME_OVERHEAD;
		dix      = 8'(idx_q - spps_pkg::FRAME_OVERHEAD);
		// big-end first for every multi-byte field
		if (evs_q)
			nb = 8'(head >> (8 * (2 - sub_q)));
		else
			nb = 8'(rep_q >> (8 * (len_q - 8'h01 - dix))); // RULE_01 RULE_06
		if (idx_q == 9'h000)
			nb = spps_pkg::PACKET_BEGIN_MARKER; // RULE_16
		else if (idx_q == 9'h001)
			nb = rout_q; // RULE_19
		else if (idx_q == 9'h002)
			nb = len_q;
		else if (idx_q == last_idx)
			nb = ~tsum_q + 8'h01; // RULE_17
		st_d = st_q;  rout_d = rout_q;  rlen_d = rlen_q;  rsum_d = rsum_q;
		rcnt_d = rcnt_q;  len_d = len_q;  tsum_d = tsum_q;  par_d = par_q;
		rep_d = rep_q;  idx_d = idx_q;  sub_d = sub_q;  evs_d = evs_q;
		txv_d = tx_valid_q;  txb_d = tx_byte_q;  call_d = call_q;
		callv_d = 1'b0;  nvms_d = 1'b0;  deaf_d = link_deaf_q;  pop = 1'b0;
		unique case (st_q)
			spps_pkg::ST_HUNT:
			begin
				if (pend_q)
				begin
					st_d   = spps_pkg::ST_BACKUP;
					nvms_d = 1'b1;
					deaf_d = 1'b1;
				end
				else if (rx && rx_byte == spps_pkg::PACKET_BEGIN_MARKER)
					st_d = spps_pkg::ST_ROUT; // RULE_16
			end
			spps_pkg::ST_ROUT:
				if (rx)
				begin
					rout_d = rx_byte;
					rsum_d = rx_byte;
					st_d   = spps_pkg::ST_LEN;
				end
			spps_pkg::ST_LEN:
				if (rx)
				begin
					rlen_d = rx_byte;
					rsum_d = rsum_q + rx_byte;
					rcnt_d = 8'h00;
					par_d  = '0;
					st_d   = (rx_byte == 8'h00) ? spps_pkg::ST_CSUM : spps_pkg::ST_DATA;
				end
			spps_pkg::ST_DATA:
				if (rx)
				begin
					rsum_d = rsum_q + rx_byte;
					rcnt_d = rcnt_q + 8'h01;
					if (rcnt_q < spps_pkg::PARAM_PAYLOAD_LEN)
						par_d = {par_q[31:0], rx_byte}; // RULE_18 RULE_01
					if (rcnt_d == rlen_q)
						st_d = spps_pkg::ST_CSUM;
				end
			spps_pkg::ST_CSUM:
				if (rx)
				begin
					idx_d  = '0;
					tsum_d = 8'h00;
					sub_d  = 2'b00;
					evs_d  = 1'b0;
					if ((8'(rsum_q + rx_byte) != 8'h00) || !rout_ok)
						st_d = spps_pkg::ST_HUNT; // RULE_13
					else if (rout_q == spps_pkg::SYSTEM_VERSION_QUERY_CODE)
					begin
						rep_d = spps_pkg::REPLY_W'({manager_version_text, platform_version_text}); // RULE_03
						len_d = spps_pkg::VERSION_PAYLOAD_LEN;
						st_d  = spps_pkg::ST_SEND;
					end
					else if (rout_q == spps_pkg::FETCH_EVENTS_CODE)
					begin
						len_d = 8'(evcnt * spps_pkg::EVENT_BYTES); // RULE_08 RULE_09
						evs_d = 1'b0;
						st_d  = spps_pkg::ST_SEND;
					end
					else
					begin
						call_d  = '{routine: rout_q, short_param_byte: par_q[39:32], long_param_word: par_q[31:0]};
						callv_d = 1'b1; // RULE_02
						st_d    = spps_pkg::ST_CALL;
					end
				end
			spps_pkg::ST_CALL:
				if (resp_valid)
				begin
					if (rout_q == spps_pkg::PORT_DETAIL_QUERY_CODE)
					begin
						rep_d = resp.detail; // RULE_04 RULE_06
						len_d = spps_pkg::DETAIL_PAYLOAD_LEN;
					end
					else
					begin
						rep_d = spps_pkg::REPLY_W'({resp.short_param_byte, resp.long_param_word}); // RULE_02 RULE_20
						len_d = spps_pkg::PARAM_PAYLOAD_LEN; // RULE_18
					end
					st_d = spps_pkg::ST_SEND;
				end
			spps_pkg::ST_SEND:
				if (!tx_valid_q || tx_ready)
				begin
					if (idx_q > last_idx)
					begin
						txv_d = 1'b0;
						st_d  = spps_pkg::ST_HUNT;
					end
					else
					begin
						txv_d = 1'b1;
						txb_d = nb;
						idx_d = idx_q + 9'h001;
						evs_d = (rout_q == spps_pkg::FETCH_EVENTS_CODE) && (idx_d >= spps_pkg::FRAME_OVERHEAD)
							&& (idx_d < last_idx);
						if (idx_q != 9'h000 && idx_q != last_idx)
							tsum_d = tsum_q + nb; // RULE_17
						if (evs_q)
						begin
							sub_d = (sub_q == 2'b10) ? 2'b00 : sub_q + 2'b01;
							pop   = (sub_q == 2'b10); // RULE_08
						end
					end
				end
			spps_pkg::ST_BACKUP:
				if (nvm_done)
				begin
					deaf_d = 1'b0;
					st_d   = spps_pkg::ST_HUNT;
				end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_q <= spps_pkg::ST_HUNT;  rout_q <= '0;  rlen_q <= '0;  rsum_q <= '0;
			rcnt_q <= '0;  len_q <= '0;  tsum_q <= '0;  par_q <= '0;  rep_q <= '0;
			idx_q <= '0;  sub_q <= '0;  evs_q <= 1'b0;  tx_valid_q <= 1'b0;
			tx_byte_q <= '0;  call_q <= '0;  call_valid_q <= 1'b0;
			nvm_start_q <= 1'b0;  link_deaf_q <= 1'b0;
		end
		else if (ce)
		begin
			st_q <= st_d;  rout_q <= rout_d;  rlen_q <= rlen_d;  rsum_q <= rsum_d;
			rcnt_q <= rcnt_d;  len_q <= len_d;  tsum_q <= tsum_d;  par_q <= par_d;
			rep_q <= rep_d;  idx_q <= idx_d;  sub_q <= sub_d;  evs_q <= evs_d;
			tx_valid_q <= txv_d;  tx_byte_q <= txb_d;  call_q <= call_d;
			call_valid_q <= callv_d;  nvm_start_q <= nvms_d;  link_deaf_q <= deaf_d;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_marker_first;
		ce && st_q == spps_pkg::ST_SEND && idx_q == 9'h000 && (!tx_valid_q || tx_ready)
			|=> tx_valid_q && tx_byte_q == spps_pkg::PACKET_BEGIN_MARKER;
	endproperty
	a_marker_first: assert property (p_marker_first) else $error("reply did not open with marker"); // RULE_16

	property p_echo;
		ce && st_q == spps_pkg::ST_SEND && idx_q == 9'h001 && tx_ready |=> tx_byte_q == rout_q;
	endproperty
	a_echo: assert property (p_echo) else $error("reply routine not echoed"); // RULE_19

	property p_csum;
		ce && st_q == spps_pkg::ST_SEND && idx_q == last_idx && (!tx_valid_q || tx_ready)
			|=> 8'(tx_byte_q + $past(tsum_q)) == 8'h00;
	endproperty
	a_csum: assert property (p_csum) else $error("reply checksum wrong"); // RULE_17

	property p_drop_bad;
		ce && st_q == spps_pkg::ST_CSUM && rx && 8'(rsum_q + rx_byte) != 8'h00
			|=> st_q == spps_pkg::ST_HUNT && !call_valid_q ##1 !tx_valid_q;
	endproperty
	a_drop_bad: assert property (p_drop_bad) else $error("bad packet answered"); // RULE_13

	property p_deaf;
		st_q == spps_pkg::ST_BACKUP |-> !tx_valid_q && link_deaf_q && !call_valid_q;
	endproperty
	a_deaf: assert property (p_deaf) else $error("link active during save"); // RULE_15

	property p_backup_cause;
		nvm_start_q |-> $past(st_q) == spps_pkg::ST_HUNT && $past(pend_q) && st_q == spps_pkg::ST_BACKUP;
	endproperty
	a_backup_cause: assert property (p_backup_cause) else $error("save started without cause"); // RULE_14

	property p_ver_len;
		ce && st_q == spps_pkg::ST_CSUM && rx && rout_ok && 8'(rsum_q + rx_byte) == 8'h00
			&& rout_q == spps_pkg::SYSTEM_VERSION_QUERY_CODE |=> len_q == spps_pkg::VERSION_PAYLOAD_LEN;
	endproperty
	a_ver_len: assert property (p_ver_len) else $error("version reply length wrong"); // RULE_03

	property p_detail_len;
		ce && st_q == spps_pkg::ST_CALL && resp_valid && rout_q == spps_pkg::PORT_DETAIL_QUERY_CODE
			|=> len_q == spps_pkg::DETAIL_PAYLOAD_LEN;
	endproperty
	a_detail_len: assert property (p_detail_len) else $error("detail reply length wrong"); // RULE_04

	property p_param_len;
		ce && st_q == spps_pkg::ST_CALL && resp_valid && rout_q != spps_pkg::PORT_DETAIL_QUERY_CODE
			|=> len_q == spps_pkg::PARAM_PAYLOAD_LEN;
	endproperty
	a_param_len: assert property (p_param_len) else $error("parameter reply not five bytes"); // RULE_18

	property p_ev_len;
		ce && st_q == spps_pkg::ST_CSUM && rx && rout_ok && 8'(rsum_q + rx_byte) == 8'h00
			&& rout_q == spps_pkg::FETCH_EVENTS_CODE
			|=> len_q == 8'($past(evcnt) * spps_pkg::EVENT_BYTES)
			&& len_q <= 8'(spps_pkg::MAX_EVENTS * spps_pkg::EVENT_BYTES);
	endproperty
	a_ev_len: assert property (p_ev_len) else $error("event reply length wrong"); // RULE_09

	c_version: cover property (st_q == spps_pkg::ST_SEND && rout_q == spps_pkg::SYSTEM_VERSION_QUERY_CODE);
	c_events: cover property (st_q == spps_pkg::ST_SEND && evs_q && pop);
	c_backup: cover property (nvm_start_q ##[1:200] st_q == spps_pkg::ST_HUNT);

endmodule
`default_nettype wire

// ### spps_server_test.sv
/*
 * Self-checking bench of the packet server: table of parameter calls,
 * then version, port detail, event, invalid packet and backup cases.
 * Assumes the host model beside it and a manager answered by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module spps_server_test;
	typedef logic [7:0] spps_bq_t[$];
	typedef struct packed {
		logic [7:0]  rtn;
		logic [39:0] req;
		logic [39:0] ans;
	} spps_row_t;

	localparam logic [63:0]   MGR_TXT = 64'h5631_2E30_0000_0000;
	localparam logic [63:0]   PLT_TXT = 64'h5032_0000_0000_0000;
	localparam logic [135:0]  DET     = 136'h00_01_04_1234_0BB8_4132_7632_2E31_3000_0000;
	localparam spps_row_t     ROWS[5] = '{
		'{8'h01, 40'h00_0000_0000, 40'hFC_0000_0000},
		'{8'h03, 40'h00_0000_0000, 40'h00_0001_D4C0},
		'{8'h10, 40'h07_0000_0001, 40'h00_0000_0000},
		'{8'h12, 40'h02_0001_86A0, 40'hFF_0000_0000},
		'{8'h27, 40'h03_0000_0000, 40'h01_0000_0000}};

	logic                  clk;
	logic                  rst_b;
	logic                  rx_valid;
	logic [7:0]            rx_byte;
	logic                  tx_valid_q;
	logic [7:0]            tx_byte_q;
	logic                  tx_ready;
	logic                  call_valid_q;
	spps_pkg::spps_call_t  call_q;
	spps_pkg::spps_call_t  cap;
	logic                  resp_valid;
	spps_pkg::spps_resp_t  resp;
	logic                  ev_valid;
	spps_pkg::spps_event_t ev;
	logic                  cfg_changed;
	logic                  nvm_done;
	logic                  nvm_start_q;
	logic                  link_deaf_q;
	logic                  slow;
	logic                  call_seen;
	int                    error_cnt;
	int                    total_checks;
	int                    cyc;
	int                    ncall;

	spps_server #(.BACKUP_CYCLES(200), .EVQ_DEPTH(85)) DUT (
		.clk(clk), .rst_b(rst_b), .ce(1'b1), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.tx_valid_q(tx_valid_q), .tx_byte_q(tx_byte_q), .tx_ready(tx_ready),
		.call_valid_q(call_valid_q), .call_q(call_q), .resp_valid(resp_valid), .resp(resp),
		.manager_version_text(MGR_TXT), .platform_version_text(PLT_TXT), .ev_valid(ev_valid), .ev(ev),
		.cfg_changed(cfg_changed), .nvm_done(nvm_done), .nvm_start_q(nvm_start_q), .link_deaf_q(link_deaf_q));

	spps_host_model host (
		.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid_q(tx_valid_q),
		.tx_byte_q(tx_byte_q), .tx_ready(tx_ready), .slow(slow));

	// ==========================================================
	// clock, manager answer and hang guard
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (call_valid_q === 1'b1)
		begin
			call_seen <= 1'b1;
			cap       <= call_q;
			ncall++;
		end
		if (cyc == 40000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	always @(negedge clk)
	begin
		resp_valid = call_seen;
		call_seen  = 1'b0;
	end

	// ==========================================================
	// helpers
	function automatic spps_bq_t split(input logic [135:0] v, input int n);
		spps_bq_t q;
		for (int i = 0; i < n; i++)
			q.push_back(v[8 * (n - i) - 1 -: 8]);
		return q;
	endfunction

	task automatic wait_bytes(input int n);
		int k;
		k = 0;
		while (host.got.size() < n && k < 3000)
		begin
			@(posedge clk);
			k++;
		end
		`CHK("reply_bytes", n, host.got.size())
	endtask

	task automatic frame_chk(input logic [7:0] rtn, input spps_bq_t pl);
		logic [7:0] s;
		wait_bytes(pl.size() + 4);
		`CHK("marker", 8'hAC, host.got[0])
		`CHK("routine", rtn, host.got[1])
		`CHK("length", 8'(pl.size()), host.got[2])
		s = rtn + 8'(pl.size());
		foreach (pl[i])
		begin
			`CHK("payload", pl[i], host.got[3 + i])
			s += pl[i];
		end
		`CHK("checksum", 8'(~s + 8'h01), host.got[pl.size() + 3])
		host.got.delete();
		repeat (2) @(negedge clk);
	endtask

	task automatic ev_test(input int n, input int first);
		spps_bq_t e;
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk);
			ev_valid = 1'b1;
			ev       = {8'(i), 8'(i) ^ 8'h5A, 8'hC3};
			if (i >= first)
				e = {e, split({8'(i), 8'(i) ^ 8'h5A, 8'hC3}, 3)};
		end
		@(negedge clk);
		ev_valid = 1'b0;
		// polled fetch, nothing is pushed unasked
		host.send(spps_pkg::FETCH_EVENTS_CODE, split(0, 5), 8'h00, 0);
		frame_chk(spps_pkg::FETCH_EVENTS_CODE, e);
	endtask

	task automatic no_reply(input int calls);
		// ends on a falling edge so the next stimulus never races the sampling edge
		repeat (60) @(negedge clk);
		`CHK("silent", 0, host.got.size())
		`CHK("no_call", calls, ncall)
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		rst_b = 1'b0; ev_valid = 1'b0; ev = '0; cfg_changed = 1'b0; nvm_done = 1'b0;
		resp = '0; slow = 1'b0; call_seen = 1'b0; resp_valid = 1'b0;
		error_cnt = 0; total_checks = 0; cyc = 0; ncall = 0;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		`CHK("rst_tx_valid", 1'b0, tx_valid_q)
		`CHK("rst_call", 1'b0, call_valid_q)
		`CHK("rst_deaf", 1'b0, link_deaf_q)
		// parameter calls, junk bytes ahead of some markers
		foreach (ROWS[r])
		begin
			resp = {ROWS[r].ans, 136'h0};
			host.send(ROWS[r].rtn, split(ROWS[r].req, 5), 8'h00, r);
			frame_chk(ROWS[r].rtn, split(ROWS[r].ans, 5));
			`CHK("call_routine", ROWS[r].rtn, cap.routine)
			`CHK("call_params", ROWS[r].req, {cap.short_param_byte, cap.long_param_word})
		end
		host.send(spps_pkg::SYSTEM_VERSION_QUERY_CODE, split(0, 5), 8'h00, 0);
		frame_chk(spps_pkg::SYSTEM_VERSION_QUERY_CODE, split({MGR_TXT, PLT_TXT}, 16));
		slow = 1'b1;
		resp = {40'h0, DET};
		host.send(spps_pkg::PORT_DETAIL_QUERY_CODE, split(40'h03_0000_0000, 5), 8'h00, 0);
		frame_chk(spps_pkg::PORT_DETAIL_QUERY_CODE, split(DET, 17));
		resp.detail.result = 8'hFE;
		host.send(spps_pkg::PORT_DETAIL_QUERY_CODE, split(40'h03_0000_0000, 5), 8'h00, 0);
		wait_bytes(21);
		// other fields disregarded after a failure code
		`CHK("detail_result", 8'hFE, host.got[3])
		host.got.delete();
		repeat (2) @(negedge clk);
		ev_test(0, 0);
		ev_test(3, 0);
		ev_test(87, 2);
		ev_test(0, 0);
		slow = 1'b0;
		// bad checksum, then routines just outside the range
		host.send(8'h03, split(0, 5), 8'h01, 0);
		no_reply(ncall);
		host.send(8'h00, split(0, 5), 8'h00, 0);
		no_reply(ncall);
		host.send(8'h29, split(0, 5), 8'h00, 0);
		no_reply(ncall);
		// backup with changed configuration
		cfg_changed = 1'b1;
		for (int k = 0; k < 250 && nvm_start_q !== 1'b1; k++)
			@(posedge clk) #1;
		`CHK("backup_start", 1'b1, nvm_start_q)
		`CHK("deaf_at_start", 1'b1, link_deaf_q)
		@(negedge clk);
		cfg_changed = 1'b0;
		host.send(8'h01, split(0, 5), 8'h00, 0);
		no_reply(ncall);
		`CHK("still_deaf", 1'b1, link_deaf_q)
		nvm_done = 1'b1;
		@(negedge clk);
		nvm_done = 1'b0;
		@(negedge clk);
		`CHK("deaf_cleared", 1'b0, link_deaf_q)
		resp = {ROWS[0].ans, 136'h0};
		host.send(8'h01, split(0, 5), 8'h00, 0);
		frame_chk(8'h01, split(ROWS[0].ans, 5));
		report_and_stop();
	end
endmodule
`default_nettype wire
